// file: bench/gpx_bus_front_end_properties.sv
module gpx_bus_front_end_properties
(
  input wire logic                       i_clock,
  input wire logic                       i_rst,
  input wire logic                       i_reset_n,
  input wire logic                       o_sda,
  input wire logic                       o_sda_oe_n,
  input wire logic [gpx_pkg::BANK_W-1:0] o_bank0_pin,
  input wire logic [gpx_pkg::BANK_W-1:0] o_bank0_pin_oe_n,
  input wire logic [gpx_pkg::BANK_W-1:0] o_bank1_pin,
  input wire logic [gpx_pkg::BANK_W-1:0] o_bank1_pin_oe_n,
  input wire logic                       o_int,
  input wire logic                       o_int_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  import gpx_pkg::*;
  default clocking cb @(posedge i_clock);
  endclocking
  // pin reset crosses a two-flop sync before it bites
  sequence s_pin_rst;
    !i_reset_n [*4];
  endsequence
  sequence s_sys_rst;
    i_rst [*5];
  endsequence
  a_cfg_all_input: assert property (i_rst |=> &{o_bank0_pin_oe_n, o_bank1_pin_oe_n})
    else $error("pin driver enabled after reset");
  a_out_default: assert property (i_rst |=> {o_bank0_pin, o_bank1_pin} == {OUT_RST, OUT_RST})
    else $error("output register not at default after reset");
  a_pin_rst_input: assert property (s_pin_rst |=> &{o_bank0_pin_oe_n, o_bank1_pin_oe_n})
    else $error("low reset pin left a driver enabled");
  a_pin_rst_hold: assert property (s_pin_rst |=> o_int_oe_n && o_bank1_pin == OUT_RST)
    else $error("low reset pin did not hold defaults");
  a_int_open_drain: assert property (o_int == 1'b0)
    else $error("interrupt pin driven high");
  a_sda_open_drain: assert property (o_sda == 1'b0)
    else $error("data line driven high");
  a_sda_rst_free: assert property (s_sys_rst |-> o_sda_oe_n)
    else $error("data line pulled during reset");
  a_int_rst_free: assert property (i_rst |=> o_int_oe_n)
    else $error("interrupt asserted after reset");
endmodule

bind gpx_bus_front_end gpx_bus_front_end_properties chk_i
(
  .i_clock,
  .i_rst,
  .i_reset_n,
  .o_sda,
  .o_sda_oe_n,
  .o_bank0_pin,
  .o_bank0_pin_oe_n,
  .o_bank1_pin,
  .o_bank1_pin_oe_n,
  .o_int,
  .o_int_oe_n
);

// file: bench/gpx_master.sv
module gpx_master
(
  input  wire logic i_clock,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  // also a repeated start: data released while the clock is low
  task automatic start();
    o_sda_low = 1'b0;
    hold(20);
    o_scl = 1'b1;
    hold(20);
    o_sda_low = 1'b1;
    hold(20);
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    hold(20);
    o_scl = 1'b1;
    hold(20);
    o_sda_low = 1'b0;
    hold(20);
  endtask
  // 1 us low and high, sampled just before the fall
  task automatic bit_x(input logic b, output logic r);
    o_sda_low = !b;
    hold(20);
    o_scl = 1'b1;
    hold(20);
    r = i_sda;
    o_scl = 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] d, input logic ack, output logic [7:0] q,
                        output logic ack_seen);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], q[i]);
    bit_x(ack, ack_seen);
  endtask
endmodule

// file: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import gpx_pkg::*;
  logic       i_clock, i_rst, i_link_clock, i_reset_n, scl, sda_low, sda_oe_n, o_sda, o_int;
  logic       int_oe_n, a;
  logic [1:0] strap;
  logic [7:0] b0_in, b1_in, b0_out, b0_oe_n, b1_out, b1_oe_n, q, d;
  logic [7:0] out_m[2], pol_m[2], cfg_m[2];
  logic [7:0] odd[5] = '{8'h42, 8'h47, 8'h4f, 8'h08, 8'h12};
  int         fails, comparisons, w;
  int         seed = 32'hcee9;
  wire        sda = ~(sda_low | ~sda_oe_n);
  always #25 i_clock = ~i_clock;
  initial
  begin
    i_link_clock = 1'b0;
    #4;
    forever #15 i_link_clock = ~i_link_clock;
  end
  gpx_master m_i (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  gpx_bus_front_end gpx_bus_front_end_i
  (
    .i_clock(i_clock), .i_rst(i_rst), .i_link_clock(i_link_clock), .i_reset_n(i_reset_n),
    .i_addr_strap_lo(strap[0]), .i_addr_strap_hi(strap[1]), .i_scl(scl), .i_sda(sda),
    .o_sda(o_sda), .o_sda_oe_n(sda_oe_n), .i_bank0_pin(b0_in), .o_bank0_pin(b0_out),
    .o_bank0_pin_oe_n(b0_oe_n), .i_bank1_pin(b1_in), .o_bank1_pin(b1_out),
    .o_bank1_pin_oe_n(b1_oe_n), .o_int(o_int), .o_int_oe_n(int_oe_n)
  );
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic reset_model();
    out_m = '{OUT_RST, OUT_RST};
    pol_m = '{POL_RST, POL_RST};
    cfg_m = '{CFG_RST, CFG_RST};
  endtask
  function automatic logic [7:0] adr(input logic rw);
    return {SLV_PREFIX, strap, rw};
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] p);
    logic [7:0] pin;
    pin = p[0] ? b1_in : b0_in;
    if (p > 8'h07)
      return 8'h00;
    case (p[2:1])
      2'h0: return pin ^ pol_m[p[0]];
      2'h1: return out_m[p[0]];
      2'h2: return pol_m[p[0]];
      default: return cfg_m[p[0]];
    endcase
  endfunction
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic [2:0] k;
    m_i.start();
    m_i.byte_x(adr(1'b0), 1'b1, q, k[0]);
    m_i.byte_x(p, 1'b1, q, k[1]);
    m_i.byte_x(v, 1'b1, q, k[2]);
    m_i.stop();
    chk("write acks", 8'h00, {5'h0, k});
    if (p inside {[8'h02:8'h07]})
      case (p[2:1])
        2'h1: out_m[p[0]] = v;
        2'h2: pol_m[p[0]] = v;
        default: cfg_m[p[0]] = v;
      endcase
  endtask
  // master nacks the single byte, so the last ack bit reads high
  task automatic rdchk(input logic [7:0] p);
    logic [3:0] k;
    m_i.start();
    m_i.byte_x(adr(1'b0), 1'b1, q, k[0]);
    m_i.byte_x(p, 1'b1, q, k[1]);
    m_i.start();
    m_i.byte_x(adr(1'b1), 1'b1, q, k[2]);
    m_i.byte_x(8'hff, 1'b1, q, k[3]);
    m_i.stop();
    chk("read acks", 8'h08, {4'h0, k});
    chk("read data", exp_rd(p), q);
  endtask
  // master acks the first byte: the same register comes back twice
  task automatic rd2chk(input logic [7:0] p);
    logic [7:0] q2;
    logic [4:0] k;
    m_i.start();
    m_i.byte_x(adr(1'b0), 1'b1, q, k[0]);
    m_i.byte_x(p, 1'b1, q, k[1]);
    m_i.start();
    m_i.byte_x(adr(1'b1), 1'b1, q, k[2]);
    m_i.byte_x(8'hff, 1'b0, q2, k[3]);
    m_i.byte_x(8'hff, 1'b1, q, k[4]);
    m_i.stop();
    chk("reread acks", 8'h10, {3'h0, k});
    chk("first read data", exp_rd(p), q2);
    chk("reread data", exp_rd(p), q);
  endtask
  task automatic pins_chk();
    chk("bank0 out", out_m[0], b0_out);
    chk("bank1 out", out_m[1], b1_out);
    chk("bank0 dir", cfg_m[0], b0_oe_n);
    chk("bank1 dir", cfg_m[1], b1_oe_n);
    chk("int idle", 8'h01, {7'h0, int_oe_n});
  endtask
  initial
  begin
    i_clock = 1'b0;
    i_rst = 1'b1;
    i_reset_n = 1'b1;
    strap = 2'h0;
    b0_in = $random(seed);
    b1_in = $random(seed);
    fails = 0;
    comparisons = 0;
    reset_model();
    m_i.hold(5);
    i_rst = 1'b0;
    m_i.hold(10);
    pins_chk();
    for (int s = 0; s < 4; s++)
      for (int t = 0; t < 5; t++)
      begin
        strap = s[1:0];
        m_i.hold(4);
        m_i.start();
        d = (t < 4) ? {SLV_PREFIX, t[1:0], 1'b0} : {SLV_PREFIX ^ 5'h01, strap, 1'b0};
        m_i.byte_x(d, 1'b1, q, a);
        m_i.stop();
        chk("address ack", {7'h0, t != s}, {7'h0, a});
      end
    strap = 2'($random(seed));
    for (int r = 2; r < 8; r++)
    begin
      d = $random(seed);
      wr(r[7:0], d);
      rdchk(r[7:0]);
    end
    rd2chk(8'h03);
    b0_in = $random(seed);
    b1_in = $random(seed);
    m_i.hold(4);
    rdchk(8'h00);
    rdchk(8'h01);
    pins_chk();
    b1_in[4] = ~b1_in[4];
    for (w = 0; w < 20 && int_oe_n !== 1'b0; w++)
      m_i.hold(1);
    chk("int asserted", 8'h00, {7'h0, int_oe_n});
    if (w == 20)
      give_verdict();
    rdchk(8'h01);
    foreach (odd[i])
    begin
      d = $random(seed);
      wr(odd[i], d);
      rdchk(odd[i]);
    end
    pins_chk();
    i_reset_n = 1'b0;
    m_i.hold(6);
    reset_model();
    pins_chk();
    i_reset_n = 1'b1;
    m_i.hold(10);
    rdchk(8'h02);
    give_verdict();
  end
endmodule

// file: rtl/gpx_bus_front_end.sv
// Functional notes
// - answer only the slave address chosen by the two strap pins.
// - address byte low bit one means read, zero means write.
// - first byte after an acknowledged write address goes to the pointer.
// - low three pointer bits pick the targeted basic register.
// - all sixteen pins come up as undriven inputs.
// - reset pin is active low.
// - bank pins 0 to 7 map straight onto register bits 0 to 7.
// - interrupt pin is open drain: pulled low or released only.
// - bit 6 with low four bits selects extended registers; 00h-07h basic.
// - while reset pin is low all registers and bus machine hold defaults.
module gpx_bus_front_end
(
  input  wire logic                         i_clock,
  input  wire logic                         i_rst,
  input  wire logic                         i_link_clock,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_addr_strap_lo,
  input  wire logic                         i_addr_strap_hi,
  input  wire logic                         i_scl,
  input  wire logic                         i_sda,
  output logic                              o_sda,
  output logic                              o_sda_oe_n,
  input  wire logic [gpx_pkg::BANK_W-1:0]   i_bank0_pin,
  output logic      [gpx_pkg::BANK_W-1:0]   o_bank0_pin,
  output logic      [gpx_pkg::BANK_W-1:0]   o_bank0_pin_oe_n,
  input  wire logic [gpx_pkg::BANK_W-1:0]   i_bank1_pin,
  output logic      [gpx_pkg::BANK_W-1:0]   o_bank1_pin,
  output logic      [gpx_pkg::BANK_W-1:0]   o_bank1_pin_oe_n,
  output logic                              o_int,
  output logic                              o_int_oe_n
);
  import gpx_pkg::*;

  logic [1:0]         rstn_sync;
  logic               dev_rst;
  logic               link_rst_req;
  logic [PIN_W-1:0]   in_s1;
  logic [PIN_W-1:0]   in_now;
  logic [1:0]         wr_sync;
  logic [1:0]         rd_sync;
  logic               wr_seen;
  logic               rd_seen;
  logic               wr_evt;
  logic               rd_evt;
  logic               link_wr_tgl;
  logic [7:0]         link_wr_data;
  logic               link_wr_is_cmd;
  logic               link_rd_req_tgl;
  logic               basic_hit;
  logic               ext_hit;
  logic [2:0]         reg_idx;
  logic [1:0]         grp;
  logic               bank;
  logic [7:0]         rd_value;

  logic [7:0]         pointer, next_pointer;
  logic [PIN_W-1:0]   out_reg, next_out_reg;
  logic [PIN_W-1:0]   pol_reg, next_pol_reg;
  logic [PIN_W-1:0]   cfg_reg, next_cfg_reg;
  logic [PIN_W-1:0]   snap, next_snap;
  logic               armed, next_armed;
  logic [7:0]         rd_data, next_rd_data;
  logic               rd_ack_tgl, next_rd_ack_tgl;
  logic               int_oe_n, next_int_oe_n;

  // pins and link toggles cross through two flops before use
  always_ff @(posedge i_clock)
  begin
    rstn_sync <= {rstn_sync[0], i_reset_n};
    in_s1     <= {i_bank1_pin, i_bank0_pin};
    in_now    <= in_s1;
    wr_sync   <= {wr_sync[0], link_wr_tgl};
    rd_sync   <= {rd_sync[0], link_rd_req_tgl};
  end

  assign dev_rst = i_rst | ~rstn_sync[1];

  always_ff @(posedge i_clock)
  begin
    link_rst_req <= dev_rst;
    if (dev_rst)
    begin
      wr_seen <= 1'b0;
      rd_seen <= 1'b0;
    end
    else
    begin
      wr_seen <= wr_sync[1];
      rd_seen <= rd_sync[1];
    end
  end

  assign wr_evt = wr_sync[1] ^ wr_seen;
  assign rd_evt = rd_sync[1] ^ rd_seen;

  gpx_link u_link
  (
    .i_link_clock    (i_link_clock),
    .i_rst_req       (link_rst_req),
    .i_scl           (i_scl),
    .i_sda           (i_sda),
    .i_addr_strap_lo (i_addr_strap_lo),
    .i_addr_strap_hi (i_addr_strap_hi),
    .o_sda_oe_n      (o_sda_oe_n),
    .o_wr_tgl        (link_wr_tgl),
    .o_wr_data       (link_wr_data),
    .o_wr_is_cmd     (link_wr_is_cmd),
    .o_rd_req_tgl    (link_rd_req_tgl),
    .i_rd_ack_tgl    (rd_ack_tgl),
    .i_rd_data       (rd_data)
  );

  // extended block decoded but not implemented: writes dropped, reads unmapped
  assign basic_hit = (pointer & CMD_BASIC_MSK) == CMD_BASIC_VAL;
  assign ext_hit   = (pointer & CMD_EXT_MSK) == CMD_EXT_VAL;
  assign reg_idx   = pointer[2:0];
  assign grp       = reg_idx[2:1];
  assign bank      = reg_idx[0];

  always_comb
  begin
    rd_value = RD_UNMAPPED;
    if (basic_hit && !ext_hit)
    begin
      case (grp)
        GRP_IN:  rd_value = in_now[bank*BANK_W +: BANK_W] ^ pol_reg[bank*BANK_W +: BANK_W];
        GRP_OUT: rd_value = out_reg[bank*BANK_W +: BANK_W];
        GRP_POL: rd_value = pol_reg[bank*BANK_W +: BANK_W];
        GRP_CFG: rd_value = cfg_reg[bank*BANK_W +: BANK_W];
        default: rd_value = RD_UNMAPPED;
      endcase
    end
  end

  always_comb
  begin
    next_pointer    = pointer;
    next_out_reg    = out_reg;
    next_pol_reg    = pol_reg;
    next_cfg_reg    = cfg_reg;
    next_snap       = snap;
    next_armed      = 1'b1;
    next_rd_data    = rd_data;
    next_rd_ack_tgl = rd_ack_tgl;
    // snapshot taken after release, never from a pin under reset
    if (!armed)
    begin
      next_snap = in_now;
    end
    if (wr_evt)
    begin
      if (link_wr_is_cmd)
      begin
        next_pointer = link_wr_data;
      end
      else if (basic_hit)
      begin
        case (grp)
          GRP_OUT: next_out_reg[bank*BANK_W +: BANK_W] = link_wr_data;
          GRP_POL: next_pol_reg[bank*BANK_W +: BANK_W] = link_wr_data;
          GRP_CFG: next_cfg_reg[bank*BANK_W +: BANK_W] = link_wr_data;
          default: next_out_reg = out_reg;
        endcase
      end
    end
    if (rd_evt)
    begin
      next_rd_data    = rd_value;
      next_rd_ack_tgl = ~rd_ack_tgl;
      if (basic_hit && grp == GRP_IN)
      begin
        next_snap[bank*BANK_W +: BANK_W] = in_now[bank*BANK_W +: BANK_W];
      end
    end
    next_int_oe_n = ~(armed && (in_now != snap));
  end

  always_ff @(posedge i_clock)
  begin
    if (dev_rst)
    begin
      pointer    <= CMD_RST;
      out_reg    <= {OUT_RST, OUT_RST};
      pol_reg    <= {POL_RST, POL_RST};
      cfg_reg    <= {CFG_RST, CFG_RST};
      snap       <= {POL_RST, POL_RST};
      armed      <= 1'b0;
      rd_data    <= RD_UNMAPPED;
      rd_ack_tgl <= 1'b0;
      int_oe_n   <= 1'b1;
    end
    else
    begin
      pointer    <= next_pointer;
      out_reg    <= next_out_reg;
      pol_reg    <= next_pol_reg;
      cfg_reg    <= next_cfg_reg;
      snap       <= next_snap;
      armed      <= next_armed;
      rd_data    <= next_rd_data;
      rd_ack_tgl <= next_rd_ack_tgl;
      int_oe_n   <= next_int_oe_n;
    end
  end

  assign o_sda            = 1'b0;
  assign o_int            = 1'b0;
  assign o_int_oe_n       = int_oe_n;
  assign o_bank0_pin      = out_reg[BANK_W-1:0];
  assign o_bank1_pin      = out_reg[PIN_W-1:BANK_W];
  assign o_bank0_pin_oe_n = cfg_reg[BANK_W-1:0];
  assign o_bank1_pin_oe_n = cfg_reg[PIN_W-1:BANK_W];
endmodule

// file: rtl/gpx_link.sv
module gpx_link
(
  input  wire logic        i_link_clock,
  input  wire logic        i_rst_req,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_addr_strap_lo,
  input  wire logic        i_addr_strap_hi,
  output logic             o_sda_oe_n,
  output logic             o_wr_tgl,
  output logic [7:0]       o_wr_data,
  output logic             o_wr_is_cmd,
  output logic             o_rd_req_tgl,
  input  wire logic        i_rd_ack_tgl,
  input  wire logic [7:0]  i_rd_data
);
  import gpx_pkg::*;

  logic [1:0]      rst_sync;
  logic [1:0]      scl_sync;
  logic [1:0]      sda_sync;
  logic [1:0]      lo_sync;
  logic [1:0]      hi_sync;
  logic [1:0]      ack_sync;
  logic            scl_d;
  logic            sda_d;
  logic            rst;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_cond;
  logic            stop_cond;
  logic            addr_match;
  logic [7:0]      rd_load;

  gpx_link_state_t state, next_state;
  logic [3:0]      bit_cnt, next_bit_cnt;
  logic [7:0]      shreg, next_shreg;
  logic            rw, next_rw;
  logic            first, next_first;
  logic            wr_tgl, next_wr_tgl;
  logic [7:0]      wr_data, next_wr_data;
  logic            wr_is_cmd, next_wr_is_cmd;
  logic            rd_req_tgl, next_rd_req_tgl;
  logic            sda_oe_n, next_sda_oe_n;

  // every pin and the cross-domain reset pass two flops first
  always_ff @(posedge i_link_clock)
  begin
    rst_sync <= {rst_sync[0], i_rst_req};
    scl_sync <= {scl_sync[0], i_scl};
    sda_sync <= {sda_sync[0], i_sda};
    lo_sync  <= {lo_sync[0], i_addr_strap_lo};
    hi_sync  <= {hi_sync[0], i_addr_strap_hi};
    ack_sync <= {ack_sync[0], i_rd_ack_tgl};
    scl_d    <= scl_sync[1];
    sda_d    <= sda_sync[1];
  end

  assign rst        = rst_sync[1];
  assign scl_rise   = scl_sync[1] & ~scl_d;
  assign scl_fall   = ~scl_sync[1] & scl_d;
  assign start_cond = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_cond  = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign addr_match = shreg[7:1] == {SLV_PREFIX, hi_sync[1], lo_sync[1]};
  // answer not back yet: send the unmapped value rather than a torn byte
  assign rd_load    = (ack_sync[1] == rd_req_tgl) ? i_rd_data : RD_UNMAPPED;

  always_comb
  begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_rw         = rw;
    next_first      = first;
    next_wr_tgl     = wr_tgl;
    next_wr_data    = wr_data;
    next_wr_is_cmd  = wr_is_cmd;
    next_rd_req_tgl = rd_req_tgl;
    if (start_cond)
    begin
      next_state   = LK_ADDR;
      next_bit_cnt = BIT_CNT_ZERO;
    end
    else if (stop_cond)
    begin
      next_state = LK_IDLE;
    end
    else
    begin
      case (state)
        LK_ADDR, LK_WR_BYTE:
        begin
          if (scl_rise)
          begin
            next_shreg   = {shreg[6:0], sda_sync[1]};
            next_bit_cnt = bit_cnt + BIT_CNT_ONE;
          end
          else if (scl_fall && bit_cnt == BIT_CNT_FULL)
          begin
            if (state == LK_WR_BYTE)
            begin
              next_state     = LK_WR_ACK;
              next_wr_data   = shreg;
              next_wr_is_cmd = first;
              next_wr_tgl    = ~wr_tgl;
            end
            else if (addr_match)
            begin
              next_state = LK_ADDR_ACK;
              next_rw    = shreg[0];
              if (shreg[0])
              begin
                next_rd_req_tgl = ~rd_req_tgl;
              end
            end
            else
            begin
              next_state = LK_IDLE;
            end
          end
        end
        LK_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            next_bit_cnt = BIT_CNT_ZERO;
            if (rw)
            begin
              next_state = LK_RD_BYTE;
              next_shreg = rd_load;
            end
            else
            begin
              next_state = LK_WR_BYTE;
              next_first = 1'b1;
            end
          end
        end
        LK_WR_ACK:
        begin
          if (scl_fall)
          begin
            next_state   = LK_WR_BYTE;
            next_bit_cnt = BIT_CNT_ZERO;
            next_first   = 1'b0;
          end
        end
        LK_RD_BYTE:
        begin
          if (scl_fall)
          begin
            next_shreg   = {shreg[6:0], 1'b1};
            next_bit_cnt = bit_cnt + BIT_CNT_ONE;
            if (bit_cnt == BIT_CNT_LAST)
            begin
              next_state = LK_RD_ACK;
            end
          end
        end
        LK_RD_ACK:
        begin
          // rw reused as "master acked": a nack ends the read
          if (scl_rise)
          begin
            next_rw = ~sda_sync[1];
            if (!sda_sync[1])
            begin
              next_rd_req_tgl = ~rd_req_tgl;
            end
          end
          else if (scl_fall)
          begin
            next_bit_cnt = BIT_CNT_ZERO;
            next_state   = rw ? LK_RD_BYTE : LK_IDLE;
            next_shreg   = rd_load;
          end
        end
        default:
        begin
          next_state = LK_IDLE;
        end
      endcase
    end
    case (next_state)
      LK_ADDR_ACK, LK_WR_ACK: next_sda_oe_n = 1'b0;
      LK_RD_BYTE:             next_sda_oe_n = next_shreg[7];
      default:                next_sda_oe_n = 1'b1;
    endcase
  end

  always_ff @(posedge i_link_clock)
  begin
    if (rst)
    begin
      state      <= LK_IDLE;
      bit_cnt    <= BIT_CNT_ZERO;
      shreg      <= CMD_RST;
      rw         <= 1'b0;
      first      <= 1'b0;
      wr_tgl     <= 1'b0;
      wr_data    <= CMD_RST;
      wr_is_cmd  <= 1'b0;
      rd_req_tgl <= 1'b0;
      sda_oe_n   <= 1'b1;
    end
    else
    begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      rw         <= next_rw;
      first      <= next_first;
      wr_tgl     <= next_wr_tgl;
      wr_data    <= next_wr_data;
      wr_is_cmd  <= next_wr_is_cmd;
      rd_req_tgl <= next_rd_req_tgl;
      sda_oe_n   <= next_sda_oe_n;
    end
  end

  assign o_sda_oe_n   = sda_oe_n;
  assign o_wr_tgl     = wr_tgl;
  assign o_wr_data    = wr_data;
  assign o_wr_is_cmd  = wr_is_cmd;
  assign o_rd_req_tgl = rd_req_tgl;
endmodule

// file: rtl/gpx_pkg.sv
package gpx_pkg;
  localparam int          BANK_W        = 8;
  localparam int          PIN_W         = 16;
  // fixed upper slave address bits; straps fill the two low bits
  localparam logic [4:0]  SLV_PREFIX    = 5'h10;
  localparam logic [7:0]  OUT_RST       = 8'hff;
  localparam logic [7:0]  POL_RST       = 8'h00;
  localparam logic [7:0]  CFG_RST       = 8'hff;
  localparam logic [7:0]  CMD_RST       = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED   = 8'h00;
  localparam logic [7:0]  CMD_BASIC_MSK = 8'hf8;
  localparam logic [7:0]  CMD_BASIC_VAL = 8'h00;
  localparam logic [7:0]  CMD_EXT_MSK   = 8'hf0;
  localparam logic [7:0]  CMD_EXT_VAL   = 8'h40;
  localparam logic [1:0]  GRP_IN        = 2'h0;
  localparam logic [1:0]  GRP_OUT       = 2'h1;
  localparam logic [1:0]  GRP_POL       = 2'h2;
  localparam logic [1:0]  GRP_CFG       = 2'h3;
  localparam logic [3:0]  BIT_CNT_FULL  = 4'h8;
  localparam logic [3:0]  BIT_CNT_LAST  = 4'h7;
  localparam logic [3:0]  BIT_CNT_ZERO  = 4'h0;
  localparam logic [3:0]  BIT_CNT_ONE   = 4'h1;

  typedef enum logic [2:0]
  {
    LK_IDLE     = 3'b000,
    LK_ADDR     = 3'b001,
    LK_ADDR_ACK = 3'b010,
    LK_WR_BYTE  = 3'b011,
    LK_WR_ACK   = 3'b100,
    LK_RD_BYTE  = 3'b101,
    LK_RD_ACK   = 3'b110
  } gpx_link_state_t;
endpackage
